// ---- core/fsro_byte_rx.sv ----
// serial byte receiver: finds link clock edges and frames bytes while selected
`timescale 1ns/100ps
`default_nettype none
module fsro_byte_rx (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire fsro_pkg::fsro_pins_t pins,
    output fsro_pkg::fsro_link_t link
);
    import fsro_pkg::*;

    typedef struct packed {
        logic sck_prev;
        logic cs_prev;
        logic [6:0] sh;
        logic [2:0] cnt;
        logic [1:0] idx;
        fsro_link_t link;
    } rx_state_t;

    rx_state_t q;
    rx_state_t d;

    // mode 0: data taken on rising link clock, byte index saturates at 3
    always_comb begin
        d = q;
        d.sck_prev = pins.sck;
        d.cs_prev = pins.cs_n;
        d.link.cs_rise = 1'b0;
        d.link.sck_fall = 1'b0;
        d.link.byte_valid = 1'b0;
        if (pins.cs_n) begin
            d.cnt = 3'h0;
            d.idx = 2'h0;
            d.link.cs_rise = !q.cs_prev;
        end else if (pins.sck && !q.sck_prev) begin
            d.sh = {q.sh[5:0], pins.si};
            d.cnt = 3'(q.cnt + 3'h1);
            if (q.cnt == 3'h7) begin
                d.link.byte_valid = 1'b1;
                d.link.data = {q.sh, pins.si};
                d.link.idx = q.idx;
                d.idx = (q.idx == 2'h3) ? 2'h3 : 2'(q.idx + 2'h1);
            end
        end else if (!pins.sck && q.sck_prev) begin
            d.link.sck_fall = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{sck_prev: 1'b0, cs_prev: 1'b1, sh: 7'h00, cnt: 3'h0, idx: 2'h0,
                   link: '0};
        end else begin
            q <= d;
        end
    end

    assign link = q.link;
endmodule : fsro_byte_rx
`default_nettype wire

// ---- core/fsro_pin_sync.sv ----
// three-flop pin synchroniser with second/third stage agreement filter
`timescale 1ns/100ps
`default_nettype none
module fsro_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // stage one feeds only stage two; filtered level moves when two and three agree
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.f[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign pin_out = q.f;
endmodule : fsro_pin_sync
`default_nettype wire

// ---- core/fsro_status_one.sv ----
// volatile status register one with its command gating over the serial link
`timescale 1ns/100ps
`default_nettype none
`include "fsro_regs.svh"
// Function
// - bit 7 follows the non-volatile write-disable bit at all times
// - program error set on failed program, cleared on successful one
// - program error also set for protected sector or locked otp target
// - clear-status (30h or 82h) clears both error flags; writes never do
// - erase error set on failed erase or protected single-sector erase
// - whole-array erase never flags error for protected sectors
// - protect select 0: legacy write updates non-volatile and volatile bits
// - protect select 1: legacy write updates only volatile protect bits
// - active protect bits refuse program and erase in selected region
// - whole-array erase runs only when active protect bits are all zero
// - write-enable command sets the write enable latch
// - write-disable command clears the write enable latch
// - latch zero: register write, program and erase are ignored
// - latch cleared when program, register write or erase succeeds
// - latch is zero after power-up, hardware and software reset
// - clear-status and reads never touch the latch
// - while busy only reads, suspends, clear-status and reset are taken
// - suspend accepted only while array program or erase is running
// - error flags update while busy; an error holds busy until clear-status
// - busy is read-only, reflects operation status only
// - layout: wdis 7, perr 6, eerr 5, protect 4:2, latch 1, busy 0
// - each reset reloads volatile bits from their non-volatile defaults
module fsro_status_one #(
    parameter logic [7:0] OPC_STATUS_ONE_READ = 8'h05,
    parameter logic [7:0] OPC_STATUS_TWO_READ = 8'h07,
    parameter logic [7:0] OPC_LEGACY_WRITE = 8'h01,
    parameter logic [7:0] OPC_PROGRAM = 8'h02,
    parameter logic [7:0] OPC_SECTOR_ERASE = 8'hd8,
    parameter logic [7:0] OPC_WHOLE_ERASE = 8'h60,
    parameter logic [7:0] OPC_ERASE_SUSPEND = 8'h75,
    parameter logic [7:0] OPC_PROGRAM_SUSPEND = 8'h85,
    parameter logic [7:0] OPC_SOFT_RESET = 8'hf0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    input wire logic [7:0] nonvolatile_status_one,
    input wire logic [7:0] nonvolatile_config_one,
    input wire logic target_protected,
    input wire logic otp_locked,
    input wire fsro_pkg::fsro_op_rsp_t op_rsp,
    output fsro_pkg::fsro_op_req_t op_req,
    output logic suspend_req,
    output logic [7:0] volatile_status_one,
    output logic [2:0] bp_active
);
    import fsro_pkg::*;

    fsro_pins_t pins_raw;
    fsro_pins_t pins_f;
    fsro_link_t link;
    fsro_state_t q;
    fsro_state_t d;

    // link pins come from the host's domain, so they pass the filtered synchroniser
    assign pins_raw = '{sck: spi_sck, cs_n: spi_cs_n, si: spi_si};

    fsro_pin_sync #(
        .W(3),
        .RST_VAL(3'b010)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(pins_raw),
        .pin_out(pins_f)
    );

    fsro_byte_rx u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pins(pins_f),
        .link(link)
    );

    // either clear-status opcode
    function automatic logic is_clear(input logic [7:0] opc);
        is_clear = (opc == `FSRO_OPC_CLEAR_A) || (opc == `FSRO_OPC_CLEAR_B);
    endfunction : is_clear

    // either suspend opcode
    function automatic logic is_suspend(input logic [7:0] opc);
        is_suspend = (opc == OPC_ERASE_SUSPEND) || (opc == OPC_PROGRAM_SUSPEND);
    endfunction : is_suspend

    // opcodes that stay live while an operation holds busy
    function automatic logic busy_ok(input logic [7:0] opc);
        busy_ok = (opc == OPC_STATUS_ONE_READ) || (opc == OPC_STATUS_TWO_READ) ||
                  (opc == `FSRO_OPC_ANY_READ) || is_clear(opc) || is_suspend(opc) ||
                  (opc == OPC_SOFT_RESET);
    endfunction : busy_ok

    // protect bits that govern the array, picked by the volatility select
    function automatic logic [2:0] pick_bp(input logic [7:0] cfg, input logic [7:0] sr,
                                           input logic [7:0] nv);
        if (cfg[`FSRO_CFG_BPVOL]) begin
            pick_bp = sr[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO];
        end else begin
            pick_bp = nv[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO];
        end
    endfunction : pick_bp

    // next state: link framing, read-out, command execution, operation completion
    always_comb begin
        logic busy_now;
        logic [7:0] opc;
        busy_now = 1'b0;
        opc = 8'h00;
        d = q;
        d.req.valid = 1'b0;
        d.susp = 1'b0;
        busy_now = q.sr[`FSRO_BIT_BUSY];
        opc = q.opcode;

        // reload of volatile defaults one cycle after any reset
        if (q.load) begin
            d.load = 1'b0;
            d.sr[`FSRO_BIT_PERR] = nonvolatile_status_one[`FSRO_BIT_PERR];
            d.sr[`FSRO_BIT_EERR] = nonvolatile_status_one[`FSRO_BIT_EERR];
            d.sr[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO] =
                nonvolatile_status_one[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO];
            d.sr[`FSRO_BIT_BUSY] = nonvolatile_status_one[`FSRO_BIT_BUSY];
            d.sr[`FSRO_BIT_WEL] = 1'b0;
            d.op_run = 1'b0;
            d.op_kind = FSRO_OP_NONE;
        end

        // byte framing: opcode first, then one argument byte where needed
        if (link.byte_valid) begin
            case (q.sh)
                FSRO_SH_OPC: begin
                    d.opcode = link.data;
                    d.has_arg = 1'b0;
                    if (link.data == OPC_STATUS_ONE_READ) begin
                        d.sh = FSRO_SH_OUT;
                        d.use_sr = 1'b1;
                        d.txcnt = 3'h0;
                    end else if (link.data == OPC_STATUS_TWO_READ) begin
                        // suspend and erase status bits are kept elsewhere; read as zero
                        d.sh = FSRO_SH_OUT;
                        d.use_sr = 1'b0;
                        d.txcnt = 3'h0;
                    end else if ((link.data == `FSRO_OPC_ANY_READ) ||
                                 (link.data == OPC_LEGACY_WRITE)) begin
                        d.sh = FSRO_SH_ARG;
                    end else begin
                        d.sh = FSRO_SH_SKIP;
                    end
                end
                FSRO_SH_ARG: begin
                    d.arg = link.data;
                    d.has_arg = 1'b1;
                    if (q.opcode == `FSRO_OPC_ANY_READ) begin
                        d.sh = FSRO_SH_OUT;
                        d.use_sr = (link.data == `FSRO_ADDR_STATUS_ONE);
                        d.txcnt = 3'h0;
                    end else begin
                        d.sh = FSRO_SH_SKIP;
                    end
                end
                FSRO_SH_OUT: begin
                    d.sh = FSRO_SH_OUT;
                end
                FSRO_SH_SKIP: begin
                    d.sh = FSRO_SH_SKIP;
                end
                default: begin
                    d.sh = FSRO_SH_SKIP;
                end
            endcase
        end

        // read-out on falling link clock; the byte is refreshed so polling sees updates
        d.so_oe = (q.sh == FSRO_SH_OUT) && !pins_f.cs_n;
        if ((q.sh == FSRO_SH_OUT) && link.sck_fall) begin
            d.txcnt = 3'(q.txcnt + 3'h1);
            if (q.txcnt == 3'h0) begin
                d.so = q.use_sr ? q.sr[7] : 1'b0;
                d.tx = q.use_sr ? {q.sr[6:0], 1'b0} : `FSRO_BYTE_RESET;
            end else begin
                d.so = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
            end
        end

        // commands execute on deselect; busy filters all but the live set
        if (link.cs_rise) begin
            d.sh = FSRO_SH_OPC;
            d.so = 1'b0;
            // a frame too short to carry an opcode must not replay the last one
            d.opcode = `FSRO_BYTE_RESET;
            d.has_arg = 1'b0;
            if (!busy_now || busy_ok(opc)) begin
                if (opc == `FSRO_OPC_WRITE_ENABLE) begin
                    d.sr[`FSRO_BIT_WEL] = 1'b1;
                end else if (opc == `FSRO_OPC_WRITE_DISABLE) begin
                    d.sr[`FSRO_BIT_WEL] = 1'b0;
                end else if (is_clear(opc)) begin
                    d.sr[`FSRO_BIT_PERR] = 1'b0;
                    d.sr[`FSRO_BIT_EERR] = 1'b0;
                    if (!q.op_run) begin
                        d.sr[`FSRO_BIT_BUSY] = 1'b0;
                    end
                end else if (is_suspend(opc)) begin
                    // only a running array operation can be suspended
                    d.susp = q.op_run && (q.op_kind != FSRO_OP_NVWR);
                end else if (opc == OPC_SOFT_RESET) begin
                    d.load = 1'b1;
                end else if (!q.sr[`FSRO_BIT_WEL]) begin
                    // latch low: modifying commands fall through untouched
                    d.sh = FSRO_SH_OPC;
                end else if ((opc == OPC_LEGACY_WRITE) && q.has_arg) begin
                    // latch and error flags are not part of the written field
                    d.sr[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO] =
                        q.arg[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO];
                    if (!nonvolatile_config_one[`FSRO_CFG_BPVOL]) begin
                        d.req = '{valid: 1'b1, kind: FSRO_OP_NVWR, whole: 1'b0,
                                  bp_data: q.arg[`FSRO_BIT_BP_HI:`FSRO_BIT_BP_LO]};
                        d.op_run = 1'b1;
                        d.op_kind = FSRO_OP_NVWR;
                        d.sr[`FSRO_BIT_BUSY] = 1'b1;
                    end else begin
                        // volatile-only write completes at once
                        d.sr[`FSRO_BIT_WEL] = 1'b0;
                    end
                end else if (opc == OPC_PROGRAM) begin
                    d.sr[`FSRO_BIT_BUSY] = 1'b1;
                    if (target_protected || otp_locked) begin
                        d.sr[`FSRO_BIT_PERR] = 1'b1;
                    end else begin
                        d.req = '{valid: 1'b1, kind: FSRO_OP_PROG, whole: 1'b0,
                                  bp_data: q.bp_act};
                        d.op_run = 1'b1;
                        d.op_kind = FSRO_OP_PROG;
                    end
                end else if (opc == OPC_SECTOR_ERASE) begin
                    d.sr[`FSRO_BIT_BUSY] = 1'b1;
                    if (target_protected) begin
                        d.sr[`FSRO_BIT_EERR] = 1'b1;
                    end else begin
                        d.req = '{valid: 1'b1, kind: FSRO_OP_ERASE, whole: 1'b0,
                                  bp_data: q.bp_act};
                        d.op_run = 1'b1;
                        d.op_kind = FSRO_OP_ERASE;
                    end
                end else if ((opc == OPC_WHOLE_ERASE) && (q.bp_act == 3'h0)) begin
                    // protected sectors met inside are skipped by the array, not flagged
                    d.req = '{valid: 1'b1, kind: FSRO_OP_ERASE, whole: 1'b1,
                              bp_data: q.bp_act};
                    d.op_run = 1'b1;
                    d.op_kind = FSRO_OP_ERASE;
                    d.sr[`FSRO_BIT_BUSY] = 1'b1;
                end
            end
        end

        // completion last, so a failure in the clear-status cycle still sets its flag
        if (q.op_run && op_rsp.done && !q.load) begin
            d.op_run = 1'b0;
            d.op_kind = FSRO_OP_NONE;
            if (op_rsp.fail) begin
                // busy stays up until clear-status, latch may stay set
                if (q.op_kind == FSRO_OP_ERASE) begin
                    d.sr[`FSRO_BIT_EERR] = 1'b1;
                end else begin
                    d.sr[`FSRO_BIT_PERR] = 1'b1;
                end
            end else begin
                d.sr[`FSRO_BIT_BUSY] = 1'b0;
                d.sr[`FSRO_BIT_WEL] = 1'b0;
                if (q.op_kind == FSRO_OP_PROG) begin
                    d.sr[`FSRO_BIT_PERR] = 1'b0;
                end
            end
        end

        // mirror and governing protect bits are tracked every cycle
        d.sr[`FSRO_BIT_WDIS] = nonvolatile_status_one[`FSRO_BIT_WDIS];
        d.bp_act = pick_bp(nonvolatile_config_one, d.sr, nonvolatile_status_one);
    end

    // async reset takes constants only; the default reload happens on the first clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{load: 1'b1, sr: `FSRO_SR_RESET, bp_act: 3'h0, op_run: 1'b0,
                   op_kind: FSRO_OP_NONE, sh: FSRO_SH_OPC, opcode: `FSRO_BYTE_RESET,
                   arg: `FSRO_BYTE_RESET, has_arg: 1'b0, use_sr: 1'b0,
                   tx: `FSRO_BYTE_RESET, txcnt: 3'h0, so: 1'b0, so_oe: 1'b0,
                   req: '0, susp: 1'b0};
        end else begin
            q <= d;
        end
    end

    // every output is a field of the registered state
    assign spi_so = q.so;
    assign spi_so_oe = q.so_oe;
    assign op_req = q.req;
    assign suspend_req = q.susp;
    assign volatile_status_one = q.sr;
    assign bp_active = q.bp_act;
endmodule : fsro_status_one
`default_nettype wire

// ---- dv/fsro_host.sv ----
// host serial controller model: frames commands, gathers read-back bytes
`timescale 1ns/100ps
`default_nettype none
module fsro_host (
    input wire logic core_clk,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    // link idles low, unselected
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // one frame, msb first, 800 ns link period; so is taken late in the
    // high phase since the device answers some core cycles after the fall
    task automatic xfer(input logic [23:0] d, input int nb, input logic rd);
        spi_cs_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            spi_si <= d[23 - i];
            repeat (4) @(posedge core_clk);
            spi_sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            rx_byte <= {rx_byte[6:0], spi_so};
            spi_sck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        spi_si <= ~spi_si; // released line must not keep its last value
        rx_valid <= rd;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        repeat (16) @(posedge core_clk); // gap of two link periods
    endtask : xfer
endmodule : fsro_host
`default_nettype wire

// ---- dv/fsro_status_one_bench.sv ----
// self-checking bench for the status register one block
`timescale 1ns/100ps
`default_nettype none
module fsro_status_one_bench;
    import fsro_pkg::*;
    logic core_clk, rst_n, sck, cs_n, si, so, so_oe, susp, rx_valid, tprot, otp;
    logic [7:0] nv, cfg, vs, rx_byte, o, a;
    logic [2:0] bp_act;
    fsro_op_rsp_t rsp;
    fsro_op_req_t req;
    logic [7:0] rdq[$];
    fsro_op_req_t opq[$];
    int n_errors, comparisons, n_susp, seed;

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    fsro_status_one i_fsro_status_one (.core_clk(core_clk), .rst_n(rst_n), .spi_sck(sck),
        .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
        .nonvolatile_status_one(nv), .nonvolatile_config_one(cfg), .target_protected(tprot),
        .otp_locked(otp), .op_rsp(rsp), .op_req(req), .suspend_req(susp),
        .volatile_status_one(vs), .bp_active(bp_act));
    fsro_host i_fsro_host (.core_clk(core_clk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
        .spi_so(so), .rx_byte(rx_byte), .rx_valid(rx_valid));

    task automatic cmp(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask : cmp

    task automatic close_out();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // results are matched against the oldest note as they appear
    always @(posedge core_clk) begin
        if (rx_valid) begin
            cmp(rx_byte === rdq[0], "status byte");
            cmp(so_oe === 1'b1, "read-out enable");
            if (rdq.size() > 0) void'(rdq.pop_front());
        end
        if (req.valid) begin
            cmp(req === opq[0], "operation request");
            if (opq.size() > 0) void'(opq.pop_front());
        end
        if (susp) n_susp++;
    end

    task automatic cmd(input logic [7:0] c);
        i_fsro_host.xfer({c, 16'h0000}, 8, 1'b0);
    endtask : cmd
    task automatic rd(input logic [7:0] e);
        rdq.push_back(e);
        i_fsro_host.xfer({8'h05, 16'h0000}, 16, 1'b1);
    endtask : rd
    task automatic op(input logic [15:0] d, input int nb, input fsro_op_t k, input logic w,
        input logic [2:0] b);
        opq.push_back('{1'b1, k, w, b});
        i_fsro_host.xfer({d, 8'h00}, nb, 1'b0);
    endtask : op
    // array engine ends the running operation
    task automatic fin(input logic f);
        rsp <= {1'b1, f};
        @(posedge core_clk);
        rsp <= 2'b00;
        repeat (4) @(posedge core_clk);
    endtask : fin

    initial begin
        seed = 32'ha70e;
        rst_n = 1'b0;
        nv = 8'h8c;
        cfg = 8'h00;
        tprot = 1'b0;
        otp = 1'b0;
        rsp = 2'b00;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h8c);
        cmd(8'h06);
        rd(8'h8e);
        cmd(8'h04);
        rd(8'h8c);
        cmd(8'h02);
        rd(8'h8c);
        cmd(8'h06);
        cmd(8'h60);
        rd(8'h8e);
        cfg <= 8'h08;
        i_fsro_host.xfer({8'h01, 16'h0000}, 16, 1'b0);
        rd(8'h80);
        cmd(8'h06);
        op(16'h6000, 8, FSRO_OP_ERASE, 1'b1, 3'b000);
        cmd(8'h04);
        rd(8'h83);
        rdq.push_back(8'h00);
        i_fsro_host.xfer({8'h07, 16'h0000}, 16, 1'b1);
        cmd(8'h75);
        fin(1'b0);
        rd(8'h80);
        cmd(8'h85);
        cmp(n_susp == 1, "suspend pulses");
        // program/erase failures, protected targets, whole erase on protected
        for (int i = 0; i < 6; i++) begin
            o = (i < 3) ? 8'h02 : (i < 5) ? 8'hd8 : 8'h60;
            tprot <= (i == 1 || i == 4 || i == 5);
            otp <= (i == 2);
            cmd(8'h06);
            if (i == 0 || i == 3 || i == 5) begin
                op({o, 8'h00}, 8, (i < 3) ? FSRO_OP_PROG : FSRO_OP_ERASE, i == 5, 3'b000);
                fin(i != 5);
            end else begin
                cmd(o);
            end
            rd((i == 5) ? 8'h80 : (i < 3) ? 8'hc3 : 8'ha3);
            if (i != 5) begin
                cmd((i % 2) ? 8'h82 : 8'h30);
                rd(8'h82);
                cmd(8'h04);
                rd(8'h80);
            end
        end
        tprot <= 1'b0;
        cfg <= 8'h00;
        nv <= 8'h80;
        cmd(8'h06);
        op({8'h01, 8'h1c}, 16, FSRO_OP_NVWR, 1'b0, 3'b111);
        rd(8'h9f);
        nv <= 8'h1c;
        fin(1'b0);
        rd(8'h1c);
        // any-register read of address 00h returns status one; random unmapped addresses read zero
        for (int i = 0; i < 4; i++) begin
            a = 8'($random(seed));
            a = (i == 0) ? 8'h00 : (a | 8'h01);
            rdq.push_back((i == 0) ? 8'h1c : 8'h00);
            i_fsro_host.xfer({8'h65, a, 8'h00}, 24, 1'b1);
        end
        cmd(8'h06);
        cmd(8'hf0);
        rd(8'h1c);
        cmd(8'h06);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h1c);
        cmp(rdq.size() == 0 && opq.size() == 0, "results missing");
        close_out();
    end

    // whole run takes about 8600 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        close_out();
    end
endmodule : fsro_status_one_bench
`default_nettype wire

// ---- dv/fsro_status_one_props.sv ----
// concurrent checks on the status register one ports
`timescale 1ns/100ps
`default_nettype none
module fsro_status_one_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] nonvolatile_status_one,
    input wire logic [7:0] nonvolatile_config_one,
    input wire fsro_pkg::fsro_op_rsp_t op_rsp,
    input wire fsro_pkg::fsro_op_req_t op_req,
    input wire logic suspend_req,
    input wire logic [7:0] volatile_status_one,
    input wire logic [2:0] bp_active
);
    import fsro_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] vs;
    // short alias keeps the properties readable
    assign vs = volatile_status_one;
    sequence s_done_ok;
        op_rsp.done && !op_rsp.fail && vs[0];
    endsequence
    sequence s_done_bad;
        op_rsp.done && op_rsp.fail && vs[0];
    endsequence
    sequence s_wdis_calm;
        $stable(nonvolatile_status_one[7]) [*3];
    endsequence
    a_wdis_mirror: assert property (s_wdis_calm |-> vs[7] == nonvolatile_status_one[7])
        else $error("write-disable mirror differs");
    a_reset_load: assert property ($rose(rst_n) |=>
        vs == {nonvolatile_status_one[7:2], 1'b0, nonvolatile_status_one[0]})
        else $error("status not reloaded after reset");
    a_ok_ends: assert property (s_done_ok |=> !vs[0] && !vs[1])
        else $error("success left busy or latch set");
    a_fail_locks: assert property (s_done_bad |=> vs[0] && (vs[6] || vs[5]))
        else $error("failure did not lock busy with error");
    a_err_holds_busy: assert property (vs[0] && (vs[6] || vs[5])
        |=> vs[0] || !(vs[6] || vs[5]))
        else $error("busy dropped while error set");
    a_req_gated: assert property (op_req.valid |-> vs[1] && vs[0] && !$past(vs[0]))
        else $error("request without latch or while busy");
    a_whole_free: assert property (op_req.valid && op_req.whole
        && op_req.kind == FSRO_OP_ERASE |-> op_req.bp_data == 3'b000 && bp_active == 3'b000)
        else $error("whole erase with protection set");
    a_susp_busy: assert property (suspend_req |-> vs[0] ##1 !suspend_req)
        else $error("suspend outside an operation");
    a_bp_nonvol: assert property ((!nonvolatile_config_one[3]
        && $stable(nonvolatile_status_one[4:2])) [*4]
        |-> bp_active == nonvolatile_status_one[4:2])
        else $error("active protect not from non-volatile bits");
    a_bp_vol: assert property ((nonvolatile_config_one[3] && $stable(vs[4:2])) [*4]
        |-> bp_active == vs[4:2])
        else $error("active protect not from volatile bits");
endmodule : fsro_status_one_props

bind fsro_status_one fsro_status_one_props i_props (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .nonvolatile_status_one(nonvolatile_status_one),
    .nonvolatile_config_one(nonvolatile_config_one),
    .op_rsp(op_rsp),
    .op_req(op_req),
    .suspend_req(suspend_req),
    .volatile_status_one(volatile_status_one),
    .bp_active(bp_active)
);
`default_nettype wire

// ---- inc/fsro_pkg.sv ----
// types shared by the status register one block
package fsro_pkg;

    // serial command phase, gray coded along opcode -> argument -> output
    typedef enum logic [1:0] {
        FSRO_SH_OPC  = 2'b00,
        FSRO_SH_ARG  = 2'b01,
        FSRO_SH_OUT  = 2'b11,
        FSRO_SH_SKIP = 2'b10
    } fsro_shift_t;

    typedef enum logic [1:0] {
        FSRO_OP_NONE  = 2'b00,
        FSRO_OP_PROG  = 2'b01,
        FSRO_OP_ERASE = 2'b11,
        FSRO_OP_NVWR  = 2'b10
    } fsro_op_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
    } fsro_pins_t;

    typedef struct packed {
        logic cs_rise;
        logic sck_fall;
        logic byte_valid;
        logic [7:0] data;
        logic [1:0] idx;
    } fsro_link_t;

    typedef struct packed {
        logic valid;
        fsro_op_t kind;
        logic whole;
        logic [2:0] bp_data;
    } fsro_op_req_t;

    typedef struct packed {
        logic done;
        logic fail;
    } fsro_op_rsp_t;

    typedef struct packed {
        logic load;
        logic [7:0] sr;
        logic [2:0] bp_act;
        logic op_run;
        fsro_op_t op_kind;
        fsro_shift_t sh;
        logic [7:0] opcode;
        logic [7:0] arg;
        logic has_arg;
        logic use_sr;
        logic [7:0] tx;
        logic [2:0] txcnt;
        logic so;
        logic so_oe;
        fsro_op_req_t req;
        logic susp;
    } fsro_state_t;

endpackage : fsro_pkg

// ---- inc/fsro_regs.svh ----
// bit positions, fixed opcodes and reset values of status register one
`ifndef FSRO_REGS_SVH
`define FSRO_REGS_SVH

`define FSRO_BIT_WDIS 7
`define FSRO_BIT_PERR 6
`define FSRO_BIT_EERR 5
`define FSRO_BIT_BP_HI 4
`define FSRO_BIT_BP_LO 2
`define FSRO_BIT_WEL 1
`define FSRO_BIT_BUSY 0
`define FSRO_CFG_BPVOL 3

`define FSRO_OPC_WRITE_ENABLE 8'h06
`define FSRO_OPC_WRITE_DISABLE 8'h04
`define FSRO_OPC_CLEAR_A 8'h30
`define FSRO_OPC_CLEAR_B 8'h82
`define FSRO_OPC_ANY_READ 8'h65

`define FSRO_ADDR_STATUS_ONE 8'h00
`define FSRO_SR_RESET 8'h00
`define FSRO_BYTE_RESET 8'h00

`endif
